/* rtl/mdd_datapath.sv */
// Multiply and divide execution datapath of the core
// What this block does
// RULE1 - Dual add overflow sets sticky saturation flag
// RULE2 - Exchange form crosses bottom/top halfword pairs
// RULE3 - Selector picks bits 15:0 or 31:16
// RULE4 - Halfword multiply gives signed 32-bit product
// RULE5 - One selector picks second operand halfword
// RULE6 - Word by half keeps top 32 of 48
// RULE7 - Unsigned long multiply splits product low/high
// RULE8 - Unsigned accumulate adds product to register pair
// RULE9 - Signed long multiply splits product low/high
// RULE10 - Signed accumulate adds product to register pair
// RULE11 - Long multiplies leave condition flags alone
// RULE12 - Issuer uses distinct high/low, no sp/pc
// RULE13 - Signed divide writes two's complement quotient
// RULE14 - Unsigned divide writes unsigned quotient
// RULE15 - Divide quotients truncate toward zero
// RULE16 - Missing destination writes back to dividend
// RULE17 - Divides alter no condition or saturation flag
// RULE18 - Divide issuer avoids stack pointer, program counter
// RULE19 - Dual add sums two signed halfword products
// RULE20 - Dual subtract: bottom product minus top product
// RULE21 - Zero divisor returns zero quotient
// RULE22 - Saturation flag sticky until software clears
`timescale 1ns/1ps
module mdd_datapath
	import mdd_pkg::*;
#(
	parameter int W  = mdd_pkg::MDD_W,
	parameter int RW = mdd_pkg::MDD_REG_IDXW
) (
	input  wire logic            clock,                 // Core clock
	input  wire logic            rst,                   // Sync reset
	input  wire logic            issue,                 // Operation valid
	input  mdd_pkg::mdd_op_t     op,                    // Operation code
	input  wire logic [W-1:0]    first_operand,         // First operand
	input  wire logic [W-1:0]    second_operand,        // Second operand
	input  wire logic [W-1:0]    acc_low,               // Low pair value
	input  wire logic [W-1:0]    acc_high,              // High pair value
	input  wire logic            first_sel_top,         // First half top
	input  wire logic            second_sel_top,        // Second half top
	input  wire logic [RW-1:0]   dest_reg,              // Destination index
	input  wire logic            dest_given,            // Dest encoded
	input  wire logic [RW-1:0]   first_operand_reg,     // Dividend index
	input  wire logic [RW-1:0]   low_destination_reg,   // Low dest index
	input  wire logic [RW-1:0]   high_destination_reg,  // High dest index
	input  wire logic            sat_flag_clear,        // Software clear
	output logic                 ready,                 // Can accept op
	output logic                 result_valid,          // Result pulse
	output logic [W-1:0]         result_low,            // Result/low word
	output logic [W-1:0]         result_high,           // High word
	output logic [RW-1:0]        result_low_reg,        // Low write index
	output logic [RW-1:0]        result_high_reg,       // High write index
	output logic                 result_high_write,     // High word valid
	output logic                 sat_flag               // Sticky saturation
);

	mdd_state_t state;
	logic [RW-1:0] div_dest;

	// ------------------------------------------------------------
	// Operand selection
	// ------------------------------------------------------------
	function automatic logic signed [15:0] pick_half(
		input logic [W-1:0] v, input logic top);
		pick_half = top ? v[31:16] : v[15:0];                 // RULE3
	endfunction : pick_half

	function automatic logic signed [31:0] smul16(
		input logic signed [15:0] a, input logic signed [15:0] b);
		smul16 = a * b;
	endfunction : smul16

	wire logic is_exch = (op == MDD_OP_DUAL_MUL_ADD_X)
		|| (op == MDD_OP_DUAL_MUL_SUB_X);
	wire logic is_dual_add = (op == MDD_OP_DUAL_MUL_ADD)
		|| (op == MDD_OP_DUAL_MUL_ADD_X);
	wire logic is_div = (op == MDD_OP_SIGNED_DIV)
		|| (op == MDD_OP_UNSIGNED_DIV);
	wire logic is_long = (op == MDD_OP_U_LONG_MUL)
		|| (op == MDD_OP_U_LONG_MUL_ACC) || (op == MDD_OP_S_LONG_MUL)
		|| (op == MDD_OP_S_LONG_MUL_ACC);

	// ------------------------------------------------------------
	// Dual halfword products
	// ------------------------------------------------------------
	wire logic signed [15:0] a_bot = pick_half(first_operand, 1'b0);
	wire logic signed [15:0] a_top = pick_half(first_operand, 1'b1);
	wire logic signed [15:0] b_lo  = pick_half(second_operand, is_exch);
	wire logic signed [15:0] b_hi  = pick_half(second_operand, !is_exch);
	wire logic signed [31:0] prod_lo = smul16(a_bot, b_lo);   // RULE2
	wire logic signed [31:0] prod_hi = smul16(a_top, b_hi);   // RULE2
	wire logic signed [32:0] dual_add =
		33'(prod_lo) + 33'(prod_hi);                          // RULE19
	wire logic signed [31:0] dual_sub = prod_lo - prod_hi;   // RULE20
	// Sum overflows when its two top bits differ
	wire logic dual_ovf = dual_add[32] ^ dual_add[31];       // RULE1

	// ------------------------------------------------------------
	// Halfword and word-by-half products
	// ------------------------------------------------------------
	wire logic signed [31:0] half_prod = smul16(
		pick_half(first_operand, first_sel_top),
		pick_half(second_operand, second_sel_top));          // RULE4
	wire logic signed [15:0] wh_mult =
		pick_half(second_operand, second_sel_top);           // RULE5
	// Only bits 47:16 reach the result
	wire logic signed [47:0] wh_prod =
		$signed(first_operand) * wh_mult;                    // RULE6

	// ------------------------------------------------------------
	// Long products and accumulate
	// ------------------------------------------------------------
	wire logic signed_long = (op == MDD_OP_S_LONG_MUL)
		|| (op == MDD_OP_S_LONG_MUL_ACC);
	wire logic long_acc = (op == MDD_OP_U_LONG_MUL_ACC)
		|| (op == MDD_OP_S_LONG_MUL_ACC);
	// Extra sign bit only for the signed long forms
	wire logic [32:0] ext_a = {signed_long & first_operand[W-1],
		first_operand};
	wire logic [32:0] ext_b = {signed_long & second_operand[W-1],
		second_operand};
	wire logic signed [65:0] long_full = $signed(ext_a) * $signed(ext_b);
	wire logic [63:0] long_prod = long_full[63:0];        // RULE7 RULE9
	wire logic [63:0] long_base = long_acc ? {acc_high, acc_low} : 64'h0;
	wire logic [63:0] long_res = long_prod + long_base;   // RULE8 RULE10

	// ------------------------------------------------------------
	// Single-cycle result select
	// ------------------------------------------------------------
	logic [W-1:0] next_low;
	always_comb begin
		unique case (op)
			MDD_OP_DUAL_MUL_ADD,
			MDD_OP_DUAL_MUL_ADD_X: next_low = dual_add[31:0];
			MDD_OP_DUAL_MUL_SUB,
			MDD_OP_DUAL_MUL_SUB_X: next_low = dual_sub;
			MDD_OP_HALFWORD_MUL:   next_low = half_prod;
			MDD_OP_WORD_BY_HALF:   next_low = wh_prod[47:16];
			default:               next_low = long_res[31:0];
		endcase
	end

	wire logic [W-1:0] div_quot;
	wire logic         div_done;
	wire logic         div_start = issue && ready && is_div;

	mdd_divider #(.W(W)) u_div (
		.clock     (clock),
		.rst       (rst),
		.start     (div_start),
		.is_signed (op == MDD_OP_SIGNED_DIV),                 // RULE13 RULE14
		.dividend  (first_operand),
		.divisor   (second_operand),
		.busy      (),
		.done      (div_done),
		.quotient  (div_quot)
	);

	// Low through a divide and its write-back cycle
	assign ready = (state == MDD_ST_IDLE);

	// ------------------------------------------------------------
	// Control and result registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state             <= MDD_ST_IDLE;
			div_dest          <= '0;
			result_valid      <= 1'b0;
			result_low        <= MDD_WORD_RST;
			result_high       <= MDD_WORD_RST;
			result_low_reg    <= '0;
			result_high_reg   <= '0;
			result_high_write <= 1'b0;
		end else begin
			result_valid      <= 1'b0;
			result_high_write <= 1'b0;
			unique case (state)
				MDD_ST_IDLE: begin
					if (issue && is_div) begin
						state    <= MDD_ST_DIV;
						div_dest <= dest_given ? dest_reg
							: first_operand_reg;                      // RULE16
					end else if (issue) begin
						result_valid      <= 1'b1;
						result_low        <= next_low;
						result_high       <= long_res[63:32];
						result_high_write <= is_long;
						result_low_reg    <= is_long ? low_destination_reg
							: dest_reg;                               // RULE12
						result_high_reg   <= high_destination_reg;
					end
				end
				MDD_ST_DIV: begin
					if (div_done) begin
						state          <= MDD_ST_DONE;
						result_valid   <= 1'b1;
						result_low     <= div_quot;
						result_low_reg <= div_dest;
					end
				end
				MDD_ST_DONE: state <= MDD_ST_IDLE;
				default:     state <= MDD_ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sticky saturation flag
	// ------------------------------------------------------------
	// Only a taken dual add sets it; long ops and divides never do
	wire logic sat_set = issue && ready && is_dual_add && dual_ovf; // RULE1
	wire logic sat_clr = sat_flag_clear && !sat_set;         // RULE11 RULE17

	// Set wins over a clear on the same edge
	always_ff @(posedge clock) begin
		if (rst)
			sat_flag <= 1'b0;
		else if (sat_set)
			sat_flag <= 1'b1;                                 // RULE22
		else if (sat_clr)
			sat_flag <= 1'b0;
	end

endmodule : mdd_datapath

/* rtl/mdd_pkg.sv */
// Package of operation codes, widths and reset values for the datapath
package mdd_pkg;

	localparam int MDD_W        = 32;
	localparam int MDD_HW       = 16;
	localparam int MDD_DIV_CYC  = 32;
	localparam int MDD_REG_IDXW = 4;

	localparam logic [5:0]  MDD_CNT_RST  = 6'h00;
	localparam logic [31:0] MDD_WORD_RST = 32'h0000_0000;

	typedef enum logic [3:0] {
		MDD_OP_DUAL_MUL_ADD   = 4'h0,
		MDD_OP_DUAL_MUL_ADD_X = 4'h1,
		MDD_OP_DUAL_MUL_SUB   = 4'h2,
		MDD_OP_DUAL_MUL_SUB_X = 4'h3,
		MDD_OP_HALFWORD_MUL   = 4'h4,
		MDD_OP_WORD_BY_HALF   = 4'h5,
		MDD_OP_U_LONG_MUL     = 4'h6,
		MDD_OP_U_LONG_MUL_ACC = 4'h7,
		MDD_OP_S_LONG_MUL     = 4'h8,
		MDD_OP_S_LONG_MUL_ACC = 4'h9,
		MDD_OP_SIGNED_DIV     = 4'hA,
		MDD_OP_UNSIGNED_DIV   = 4'hB
	} mdd_op_t;

	typedef enum logic [1:0] {
		MDD_ST_IDLE = 2'b00,
		MDD_ST_DIV  = 2'b01,
		MDD_ST_DONE = 2'b11
	} mdd_state_t;

endpackage : mdd_pkg

/* rtl/mdd_divider.sv */
// Sequential restoring divider, unsigned core with sign fix-up
`timescale 1ns/1ps
module mdd_divider
	import mdd_pkg::*;
#(
	parameter int W = mdd_pkg::MDD_W
) (
	input  wire logic         clock,      // Core clock
	input  wire logic         rst,        // Sync reset
	input  wire logic         start,      // Begin a divide
	input  wire logic         is_signed,  // Two's complement divide
	input  wire logic [W-1:0] dividend,   // Value to divide
	input  wire logic [W-1:0] divisor,    // Divisor
	output logic              busy,       // Divide in progress
	output logic              done,       // Quotient valid pulse
	output logic [W-1:0]      quotient    // Result
);

	logic [W-1:0] rem;
	logic [W-1:0] quo;
	logic [W-1:0] dvs;
	logic         neg_q;
	logic         zero_div;
	logic [5:0]   count;

	function automatic logic [W-1:0] mag(input logic [W-1:0] v,
		input logic s);
		mag = (s && v[W-1]) ? -v : v;
	endfunction : mag

	wire logic [W:0]   trial    = {rem, quo[W-1]} - {1'b0, dvs};
	wire logic         fits     = ~trial[W];
	wire logic [W-1:0] next_rem = fits ? trial[W-1:0]
		: {rem[W-2:0], quo[W-1]};
	wire logic [W-1:0] next_quo = {quo[W-2:0], fits};
	wire logic         last     = (count == 6'(W - 1));

	always_ff @(posedge clock) begin
		if (rst) begin
			busy     <= 1'b0;
			done     <= 1'b0;
			count    <= MDD_CNT_RST;
			rem      <= MDD_WORD_RST;
			quo      <= MDD_WORD_RST;
			dvs      <= MDD_WORD_RST;
			neg_q    <= 1'b0;
			zero_div <= 1'b0;
			quotient <= MDD_WORD_RST;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy     <= 1'b1;
				count    <= MDD_CNT_RST;
				rem      <= MDD_WORD_RST;
				quo      <= mag(dividend, is_signed);
				dvs      <= mag(divisor, is_signed);
				neg_q    <= is_signed && (dividend[W-1] ^ divisor[W-1]);
				zero_div <= (divisor == '0);
			end else if (busy) begin
				rem   <= next_rem;
				quo   <= next_quo;
				count <= count + 6'h01;
				if (last) begin
					busy <= 1'b0;
					done <= 1'b1;
					// Magnitude quotient truncates, sign applied after
					if (zero_div)                                 // RULE21
						quotient <= MDD_WORD_RST;
					else if (neg_q)                               // RULE15
						quotient <= -next_quo;
					else
						quotient <= next_quo;
				end
			end
		end
	end

endmodule : mdd_divider

/* sim/mdd_regfile.sv */
// Register file model giving pair contents and taking results
`timescale 1ns/1ps
module mdd_regfile
	import mdd_pkg::*;
(
	input  wire logic        clock,      // Core clock
	input  wire logic        rst,        // Sync reset
	input  wire logic [3:0]  rd_lo_idx,  // Low pair index
	input  wire logic [3:0]  rd_hi_idx,  // High pair index
	input  wire logic        wr_en,      // Result valid
	input  wire logic        wr_hi_en,   // High word valid
	input  wire logic [3:0]  wr_lo_idx,  // Low write index
	input  wire logic [3:0]  wr_hi_idx,  // High write index
	input  wire logic [31:0] wr_lo_val,  // Low result
	input  wire logic [31:0] wr_hi_val,  // High result
	output logic      [31:0] acc_low,    // Low pair contents
	output logic      [31:0] acc_high    // High pair contents
);
	logic [31:0] regs [16];
	assign acc_low  = regs[rd_lo_idx];
	assign acc_high = regs[rd_hi_idx];
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= MDD_WORD_RST;
			end
		end else if (wr_en) begin
			regs[wr_lo_idx] <= wr_lo_val;
			if (wr_hi_en) begin
				regs[wr_hi_idx] <= wr_hi_val;
			end
		end
	end
endmodule : mdd_regfile

/* sim/mdd_datapath_sva.sv */
// Assertion checker for the multiply and divide datapath
`timescale 1ns/1ps
module mdd_datapath_sva
	import mdd_pkg::*;
(
	input wire logic        clock,                // Core clock
	input wire logic        rst,                  // Sync reset
	input wire logic        issue,                // Operation valid
	input mdd_pkg::mdd_op_t op,                   // Operation code
	input wire logic [31:0] first_operand,        // First operand
	input wire logic [31:0] second_operand,       // Second operand
	input wire logic        first_sel_top,        // First half top
	input wire logic        second_sel_top,       // Second half top
	input wire logic [3:0]  dest_reg,             // Destination index
	input wire logic        dest_given,           // Dest encoded
	input wire logic [3:0]  first_operand_reg,    // Dividend index
	input wire logic [3:0]  low_destination_reg,  // Low dest index
	input wire logic [3:0]  high_destination_reg, // High dest index
	input wire logic        sat_flag_clear,       // Software clear
	input wire logic        ready,                // Can accept op
	input wire logic        result_valid,         // Result pulse
	input wire logic [31:0] result_low,           // Result word
	input wire logic [3:0]  result_low_reg,       // Low write index
	input wire logic [3:0]  result_high_reg,      // High write index
	input wire logic        result_high_write,    // High word valid
	input wire logic        sat_flag              // Sticky saturation
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic tk = issue && ready;
	wire logic dv = tk && op >= MDD_OP_SIGNED_DIV;
	wire logic lg = tk && op >= MDD_OP_U_LONG_MUL && op <= MDD_OP_S_LONG_MUL_ACC;
	wire logic da = tk && op <= MDD_OP_DUAL_MUL_ADD_X;
	wire logic [3:0] dd = dest_given ? dest_reg : first_operand_reg;
	wire logic [15:0] ha = first_sel_top ? first_operand[31:16]
		: first_operand[15:0];
	wire logic [15:0] hb = second_sel_top ? second_operand[31:16]
		: second_operand[15:0];
	wire logic [31:0] hp = $signed(ha) * $signed(hb);
	chk_hw_product: assert property (tk && op == MDD_OP_HALFWORD_MUL
		|=> result_low == $past(hp)) else $error("halfword product wrong");
	chk_div_latency: assert property (dv |-> ##34 result_valid)
		else $error("divide result late");
	chk_div_hold: assert property (dv |=> !ready [*8])
		else $error("ready during divide");
	chk_div_dest: assert property (dv
		|-> ##34 result_low_reg == $past(dd, 34)) else $error("divide dest");
	chk_long_regs: assert property (lg |=> result_high_write
		&& result_low_reg == $past(low_destination_reg)
		&& result_high_reg == $past(high_destination_reg))
		else $error("long dest wrong");
	chk_high_pair: assert property (result_high_write |-> result_valid)
		else $error("high word without result");
	chk_sat_sticky: assert property (sat_flag && !sat_flag_clear
		|=> sat_flag) else $error("flag dropped");
	chk_sat_cause: assert property ($rose(sat_flag) |-> $past(da))
		else $error("flag set by other op");
	chk_sat_clear: assert property (sat_flag_clear && !da |=> !sat_flag)
		else $error("flag not cleared");
endmodule : mdd_datapath_sva
bind mdd_datapath mdd_datapath_sva u_sva (.clock, .rst, .issue, .op,
	.first_operand, .second_operand, .first_sel_top, .second_sel_top,
	.dest_reg, .dest_given, .first_operand_reg, .low_destination_reg,
	.high_destination_reg, .sat_flag_clear, .ready, .result_valid,
	.result_low, .result_low_reg, .result_high_reg, .result_high_write,
	.sat_flag);

/* sim/mdd_datapath_tb.sv */
// Self-checking testbench of the multiply and divide datapath
`timescale 1ns/1ps
module mdd_datapath_tb;
	import mdd_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic issue = 1'b0;
	mdd_op_t op = MDD_OP_DUAL_MUL_ADD;
	logic [31:0] first_operand = 32'h0, second_operand = 32'h0;
	logic [31:0] acc_low, acc_high, result_low, result_high;
	logic first_sel_top = 1'b0, second_sel_top = 1'b0, sat_flag_clear = 1'b0;
	logic [3:0] dest_reg = 4'h6, first_operand_reg = 4'h5;
	logic [3:0] low_destination_reg = 4'h1, high_destination_reg = 4'h2;
	logic dest_given = 1'b0;
	logic ready, result_valid, result_high_write, sat_flag;
	logic [3:0] result_low_reg, result_high_reg;
	int err_count = 0, n_tests = 0;
	// Operand and result patterns reused across scenarios
	localparam logic [31:0] DA = 32'h00030002, DB = 32'h00050004;
	localparam logic [31:0] HA = 32'h80000003, HB = 32'hFFFF7FFF;
	localparam logic [31:0] HM = 32'h00008000, DM = 32'h80008000;
	localparam logic [31:0] WB = 32'hFFFF0002, MIN = 32'h80000000;
	localparam logic [31:0] ONES = 32'hFFFFFFFF, M2 = 32'hFFFFFFFE;
	localparam logic [31:0] M3 = 32'hFFFFFFFD, M5 = 32'hFFFFFFFB;
	localparam logic [31:0] M7 = 32'hFFFFFFF9;
	mdd_datapath dut (.clock, .rst, .issue, .op, .first_operand,
		.second_operand, .acc_low, .acc_high, .first_sel_top,
		.second_sel_top, .dest_reg, .dest_given, .first_operand_reg,
		.low_destination_reg, .high_destination_reg, .sat_flag_clear,
		.ready, .result_valid, .result_low, .result_high, .result_low_reg,
		.result_high_reg, .result_high_write, .sat_flag);
	mdd_regfile rf (.clock, .rst, .rd_lo_idx(low_destination_reg),
		.rd_hi_idx(high_destination_reg), .wr_en(result_valid),
		.wr_hi_en(result_high_write), .wr_lo_idx(result_low_reg),
		.wr_hi_idx(result_high_reg), .wr_lo_val(result_low),
		.wr_hi_val(result_high), .acc_low, .acc_high);
	always #5 clock = ~clock;
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: word %h expected %h", $time, g, e);
		end
	endtask : cmp_w
	task automatic cmp_b(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: bit %b expected %b", $time, g, e);
		end
	endtask : cmp_b
	// Issue one op, wait for its result, compare the words
	task automatic go(input mdd_op_t o, input logic [31:0] a,
		input logic [31:0] b, input logic [1:0] sel,
		input logic [31:0] el, input logic [31:0] eh);
		int n;
		logic lng;
		n = 0;
		lng = (o >= MDD_OP_U_LONG_MUL) && (o <= MDD_OP_S_LONG_MUL_ACC);
		while (ready !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		op = o;
		first_operand = a;
		second_operand = b;
		{first_sel_top, second_sel_top} = sel;
		issue = 1'b1;
		@(posedge clock);
		#1;
		issue = 1'b0;
		n = 0;
		while (result_valid !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		cmp_b(result_valid, 1'b1);
		cmp_w(result_low, el);
		cmp_b(result_high_write, lng);
		if (lng) begin
			cmp_w(result_high, eh);
			cmp_w({28'h0, result_low_reg}, 32'h1);
			cmp_w({28'h0, result_high_reg}, 32'h2);
		end
		@(posedge clock);
		#1;
	endtask : go
	initial begin
		#50000;
		err_count++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clock);
		#1;
		rst = 1'b0;
		cmp_b(ready, 1'b1);
		cmp_b(sat_flag, 1'b0);
		go(MDD_OP_DUAL_MUL_ADD, DA, DB, 2'b00, 32'h17, 0);
		go(MDD_OP_DUAL_MUL_ADD_X, DA, DB, 2'b00, 32'h16, 0);
		go(MDD_OP_DUAL_MUL_SUB, DA, DB, 2'b00, M7, 0);
		go(MDD_OP_DUAL_MUL_SUB_X, DA, DB, 2'b00, M2, 0);
		go(MDD_OP_HALFWORD_MUL, HA, HB, 2'b11, 32'h8000, 0);
		go(MDD_OP_HALFWORD_MUL, HA, HB, 2'b00, 32'h17FFD, 0);
		go(MDD_OP_HALFWORD_MUL, HA, HB, 2'b10, 32'hC0008000, 0);
		go(MDD_OP_HALFWORD_MUL, HA, HB, 2'b01, M3, 0);
		go(MDD_OP_HALFWORD_MUL, HM, HM, 2'b00, 32'h40000000, 0);
		cmp_b(sat_flag, 1'b0);
		go(MDD_OP_WORD_BY_HALF, MIN, WB, 2'b00, 32'hFFFF0000, 0);
		go(MDD_OP_WORD_BY_HALF, MIN, WB, 2'b01, 32'h8000, 0);
		go(MDD_OP_DUAL_MUL_ADD, DM, DM, 2'b00, MIN, 0);
		cmp_b(sat_flag, 1'b1);
		go(MDD_OP_U_LONG_MUL, ONES, ONES, 2'b00, 32'h1, M2);
		go(MDD_OP_U_LONG_MUL_ACC, ONES, 32'h2, 2'b00, ONES, ONES);
		go(MDD_OP_S_LONG_MUL, ONES, 32'h2, 2'b00, M2, ONES);
		go(MDD_OP_S_LONG_MUL_ACC, ONES, 32'h3, 2'b00, M5, ONES);
		cmp_b(sat_flag, 1'b1);
		go(MDD_OP_SIGNED_DIV, M7, 32'h2, 2'b00, M3, 0);
		cmp_w({28'h0, result_low_reg}, 32'h5);
		dest_given = 1'b1;
		go(MDD_OP_UNSIGNED_DIV, M7, 32'h2, 2'b00, 32'h7FFFFFFC, 0);
		cmp_w({28'h0, result_low_reg}, 32'h6);
		go(MDD_OP_SIGNED_DIV, 32'h7, M2, 2'b00, M3, 0);
		go(MDD_OP_UNSIGNED_DIV, 32'h7, 32'h0, 2'b00, 32'h0, 0);
		cmp_b(sat_flag, 1'b1);
		sat_flag_clear = 1'b1;
		@(posedge clock);
		#1;
		sat_flag_clear = 1'b0;
		cmp_b(sat_flag, 1'b0);
		// Overflow and clear on the same edge: the set wins
		op = MDD_OP_DUAL_MUL_ADD;
		first_operand = DM;
		second_operand = DM;
		issue = 1'b1;
		sat_flag_clear = 1'b1;
		@(posedge clock);
		#1;
		issue = 1'b0;
		sat_flag_clear = 1'b0;
		cmp_b(sat_flag, 1'b1);
		cmp_b(result_valid, 1'b1);
		cmp_w(result_low, MIN);
		sat_flag_clear = 1'b1;
		@(posedge clock);
		#1;
		sat_flag_clear = 1'b0;
		cmp_b(sat_flag, 1'b0);
		// Reset in the middle of a divide
		op = MDD_OP_UNSIGNED_DIV;
		issue = 1'b1;
		@(posedge clock);
		#1;
		issue = 1'b0;
		cmp_b(ready, 1'b0);
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		cmp_b(ready, 1'b1);
		cmp_b(result_valid, 1'b0);
		go(MDD_OP_UNSIGNED_DIV, 32'h64, 32'h7, 2'b00, 32'hE, 0);
		test_done();
	end
endmodule : mdd_datapath_tb
